// [tx_ctl_regs.svh]
// Register offsets, field positions, reset values and fixed sizes of the transmit control block
`ifndef TX_CTL_REGS_SVH
`define TX_CTL_REGS_SVH

`define TXC_OFF_TRANSMIT_CONFIG 8'h70
`define TXC_OFF_HARDWARE_CONFIG 8'h74
`define TXC_OFF_TX_STATUS 8'h78

`define TXC_BIT_STATUS_FLUSH 15
`define TXC_BIT_DATA_FLUSH 14
`define TXC_BIT_OVERRUN_ALLOW 2
`define TXC_BIT_TX_ENABLE 1
`define TXC_BIT_STOP 0

`define TXC_BIT_STRAP 24
`define TXC_BIT_THRESH_MODE 21
`define TXC_BIT_STORE_FWD 20
`define TXC_POS_FIFO_SIZE 16
`define TXC_POS_THRESH 12

`define TXC_RESET_FIFO_SIZE 4'h5
`define TXC_MIN_FIFO_SIZE 4'h2
`define TXC_MAX_FIFO_SIZE 4'hE
`define TXC_TOTAL_KB 5'h10
`define TXC_KB_WORDS 8'h00
`define TXC_STATUS_WORDS 12'h080

`endif

// [tx_ctl_pkg.sv]
// Types shared by the transmit control block
package tx_ctl_pkg;

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_FETCH,
        TX_WAITDATA,
        TX_SEND
    } tx_state_type;

    typedef struct packed {
        logic last;
        logic [31:0] data;
    } link_word_type;

endpackage

// [tx_word_ram.sv]
// Transmit data word memory with registered read data
`timescale 1ns/1ps

module tx_word_ram #(
    parameter int DEPTH = 3456,
    parameter int ADDR_W = 12
) (
    input wire logic clk, // System clock
    input wire logic wrEn, // Write strobe
    input wire logic [ADDR_W-1:0] wrAddr, // Write address
    input wire tx_ctl_pkg::link_word_type wrData, // Word to store
    input wire logic rdEn, // Read strobe
    input wire logic [ADDR_W-1:0] rdAddr, // Read address
    output tx_ctl_pkg::link_word_type rdData // Word read, one cycle later
);

    tx_ctl_pkg::link_word_type mem [DEPTH];

    initial begin
        if (DEPTH > (1 << ADDR_W)) begin
            $error("tx_word_ram: DEPTH does not fit ADDR_W");
        end
    end

    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge clk) begin
        if (rdEn) begin
            rdData <= mem[rdAddr];
        end
    end

endmodule

// [tx_control.sv]
// Transmit control, FIFO sizing and APB register slave of the Ethernet controller
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "tx_ctl_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// R1 - Status flush empties status FIFO, self-clears
// R2 - Data flush empties data FIFO, self-clears
// R3 - Full status FIFO suspends unless overrun allowed
// R4 - Status full event independent of overrun allow
// R5 - Enabled transmitter sends queued frames
// R6 - Enable clears itself after stop completes
// R7 - Stop finishes current frame, then clears
// R8 - Writes to stop ignored while high
// R9 - Crossover strap level readable, read-only
// R10 - Threshold mode picks table; ignored in store-forward
// R11 - Host sets mode for 10Mbps, clears for 100Mbps
// R12 - Store-forward waits for a complete frame
// R13 - Cut-through starts at selected threshold
// R14 - Host must feed data faster than link
// R15 - Four-bit size field, 1KB steps, resets 5h
// R16 - 512 bytes of allocation go to status
// R17 - Host programs at least 2KB transmit space
// R18 - Data FIFO carries commands and payload interleaved
// R19 - Receive side gets 16KB minus transmit
// R20 - Start thresholds are implementation parameters
// R21 - Control bits reset zero, reserved read zero
module tx_control #(
    parameter int DATA_DEPTH = 3456, // Words of data memory, 14KB minus status share
    parameter int STATUS_DEPTH = 128, // Status words, 512 bytes
    parameter logic [47:0] START_FAST = 48'h200_100_080_040, // Thresholds in words, mode 0
    parameter logic [47:0] START_SLOW = 48'h100_080_040_020 // Thresholds in words, mode 1
) (
    input wire logic clk, // System clock, 25 MHz
    input wire logic reset, // Synchronous reset, active high
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic autoCrossoverStrap, // Crossover strap pin level
    input wire logic fillValid, // Host-side word offered
    input wire tx_ctl_pkg::link_word_type fillWord, // Command or payload word, last marks frame end
    output logic fillReady, // Data FIFO can take a word
    output logic linkValid, // Word offered to the MAC
    output tx_ctl_pkg::link_word_type linkWord, // Word toward the MAC
    input wire logic linkReady, // MAC takes the word
    input wire logic statusPop, // Host consumed one status word
    output logic statusFull, // Status FIFO full level
    output logic statusFullPulse, // One cycle when the status FIFO becomes full
    output logic [4:0] rxSpaceKb // KB left for receive FIFOs
);

    localparam int ADDR_W = $clog2(DATA_DEPTH);
    localparam int COUNT_W = ADDR_W + 1;
    localparam int STAT_W = $clog2(STATUS_DEPTH + 1);

    initial begin
        if (DATA_DEPTH < 3456 || ADDR_W > 12) begin
            $error("tx_control: DATA_DEPTH must be 3456 to 4096 words");
        end
        if (STATUS_DEPTH < 1) begin
            $error("tx_control: STATUS_DEPTH must be positive");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    logic statusOverrunAllow;
    logic txEnable;
    logic stopRequest;
    logic thresholdMode;
    logic storeAndForward;
    logic [3:0] transmitFifoSize;
    logic [1:0] thresholdField;
    logic strapLatched;
    logic strapTaken;

    tx_ctl_pkg::tx_state_type state;
    logic [ADDR_W-1:0] wrPtr;
    logic [ADDR_W-1:0] rdPtr;
    logic [COUNT_W-1:0] usedCount;
    logic [COUNT_W-1:0] frameCount;
    logic [STAT_W-1:0] statusCount;
    logic [11:0] capacityWords;
    tx_ctl_pkg::link_word_type ramData;

    logic busDone;
    logic busWrite;
    logic hitTxCfg;
    logic hitHwCfg;
    logic hitStatus;
    logic dataFlush;
    logic statusFlush;
    logic wrAccept;
    logic rdIssue;
    logic frameDone;
    logic haltNow;
    logic canStart;
    logic [11:0] startLevel;
    logic [3:0] sizeClamped;
    logic [COUNT_W-1:0] next_usedCount;
    logic [STAT_W-1:0] next_statusCount;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode

    assign busDone = psel && penable && pready;
    assign busWrite = busDone && pwrite;
    assign hitTxCfg = paddr == `TXC_OFF_TRANSMIT_CONFIG;
    assign hitHwCfg = paddr == `TXC_OFF_HARDWARE_CONFIG;
    assign hitStatus = paddr == `TXC_OFF_TX_STATUS;
    assign statusFlush = busWrite && hitTxCfg && pwdata[`TXC_BIT_STATUS_FLUSH]; // R1
    assign dataFlush = busWrite && hitTxCfg && pwdata[`TXC_BIT_DATA_FLUSH]; // R2

    // One wait state: pready rises the cycle after the access phase starts
    always_ff @(posedge clk) begin
        if (reset) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            prdata <= 32'h0000_0000; // R21
            pslverr <= !(hitTxCfg || hitHwCfg || hitStatus);
            if (!pwrite && hitTxCfg) begin
                prdata[`TXC_BIT_OVERRUN_ALLOW] <= statusOverrunAllow;
                prdata[`TXC_BIT_TX_ENABLE] <= txEnable;
                prdata[`TXC_BIT_STOP] <= stopRequest;
            end
            if (!pwrite && hitHwCfg) begin
                prdata[`TXC_BIT_STRAP] <= strapLatched; // R9
                prdata[`TXC_BIT_THRESH_MODE] <= thresholdMode;
                prdata[`TXC_BIT_STORE_FWD] <= storeAndForward;
                prdata[`TXC_POS_FIFO_SIZE +: 4] <= transmitFifoSize;
                prdata[`TXC_POS_THRESH +: 2] <= thresholdField;
            end
            if (!pwrite && hitStatus) begin
                prdata[31] <= state != tx_ctl_pkg::TX_IDLE;
                prdata[27:16] <= 12'(usedCount);
                prdata[15:0] <= 16'(statusCount);
            end
        end else begin
            pslverr <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit configuration

    // Halted means no frame in flight
    assign haltNow = stopRequest && state == tx_ctl_pkg::TX_IDLE;

    always_ff @(posedge clk) begin
        if (reset) begin
            stopRequest <= 1'b0; // R21
        end else if (haltNow) begin
            stopRequest <= 1'b0; // R7
        end else if (busWrite && hitTxCfg && !stopRequest) begin
            stopRequest <= pwdata[`TXC_BIT_STOP]; // R8
        end
    end

    // Completion of a stop wins over a host write in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            txEnable <= 1'b0;
            statusOverrunAllow <= 1'b0;
        end else begin
            if (haltNow) begin
                txEnable <= 1'b0; // R6
            end else if (busWrite && hitTxCfg) begin
                txEnable <= pwdata[`TXC_BIT_TX_ENABLE];
            end
            if (busWrite && hitTxCfg) begin
                statusOverrunAllow <= pwdata[`TXC_BIT_OVERRUN_ALLOW];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Hardware configuration and allocation

    always_ff @(posedge clk) begin
        if (reset) begin
            thresholdMode <= 1'b0;
            storeAndForward <= 1'b0;
            thresholdField <= 2'h0;
            transmitFifoSize <= `TXC_RESET_FIFO_SIZE; // R15
        end else if (busWrite && hitHwCfg) begin
            thresholdMode <= pwdata[`TXC_BIT_THRESH_MODE];
            storeAndForward <= pwdata[`TXC_BIT_STORE_FWD];
            thresholdField <= pwdata[`TXC_POS_THRESH +: 2];
            transmitFifoSize <= pwdata[`TXC_POS_FIFO_SIZE +: 4]; // R15
        end
    end

    // Strap caught on the first edge after reset release, then frozen
    always_ff @(posedge clk) begin
        if (reset) begin
            strapTaken <= 1'b0;
            strapLatched <= 1'b0;
        end else if (!strapTaken) begin
            strapTaken <= 1'b1;
            strapLatched <= autoCrossoverStrap; // R9
        end
    end

    // Out-of-range sizes are clamped so the data FIFO never wraps wrongly
    always_comb begin
        sizeClamped = transmitFifoSize;
        if (transmitFifoSize < `TXC_MIN_FIFO_SIZE) begin
            sizeClamped = `TXC_MIN_FIFO_SIZE; // R17
        end else if (transmitFifoSize > `TXC_MAX_FIFO_SIZE) begin
            sizeClamped = `TXC_MAX_FIFO_SIZE; // R15
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            capacityWords <= 12'h000;
            rxSpaceKb <= 5'h00;
        end else begin
            capacityWords <= {sizeClamped, `TXC_KB_WORDS} - `TXC_STATUS_WORDS; // R16
            rxSpaceKb <= `TXC_TOTAL_KB - {1'b0, sizeClamped}; // R19
        end
    end

    // Thresholds are parameters; mode chooses the table
    assign startLevel = thresholdMode ? START_SLOW[thresholdField * 12 +: 12]
                                      : START_FAST[thresholdField * 12 +: 12]; // R10 R20

    ////////////////////////////////////////////////////////////////////////////
    // Data FIFO

    assign wrAccept = fillValid && fillReady && !dataFlush;
    assign rdIssue = state == tx_ctl_pkg::TX_FETCH && usedCount != '0 && !dataFlush;
    assign frameDone = state == tx_ctl_pkg::TX_SEND && linkReady && linkWord.last && !dataFlush;

    tx_word_ram #(
        .DEPTH(DATA_DEPTH),
        .ADDR_W(ADDR_W)
    ) wordRam (
        .clk(clk),
        .wrEn(wrAccept), // R18
        .wrAddr(wrPtr),
        .wrData(fillWord),
        .rdEn(rdIssue),
        .rdAddr(rdPtr),
        .rdData(ramData)
    );

    always_comb begin
        next_usedCount = usedCount + COUNT_W'(wrAccept) - COUNT_W'(rdIssue);
        if (dataFlush) begin
            next_usedCount = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || dataFlush) begin
            wrPtr <= '0; // R2
            rdPtr <= '0;
            usedCount <= '0;
        end else begin
            usedCount <= next_usedCount;
            if (wrAccept) begin
                wrPtr <= wrPtr == ADDR_W'(DATA_DEPTH - 1) ? '0 : wrPtr + 1'b1;
            end
            if (rdIssue) begin
                rdPtr <= rdPtr == ADDR_W'(DATA_DEPTH - 1) ? '0 : rdPtr + 1'b1;
            end
        end
    end

    // Registered ready: next-cycle write still fits the programmed share
    always_ff @(posedge clk) begin
        if (reset) begin
            fillReady <= 1'b0;
        end else begin
            fillReady <= next_usedCount < COUNT_W'(capacityWords) && !dataFlush;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || dataFlush) begin
            frameCount <= '0;
        end else begin
            frameCount <= frameCount + COUNT_W'(wrAccept && fillWord.last) - COUNT_W'(frameDone);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status FIFO occupancy

    always_comb begin
        next_statusCount = statusCount;
        if (statusPop && statusCount != '0) begin
            next_statusCount = next_statusCount - 1'b1;
        end
        // With overrun allowed a status arriving at full is dropped
        if (frameDone && next_statusCount != STAT_W'(STATUS_DEPTH)) begin
            next_statusCount = next_statusCount + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || statusFlush) begin
            statusCount <= '0; // R1
            statusFull <= 1'b0;
            statusFullPulse <= 1'b0;
        end else begin
            statusCount <= next_statusCount;
            statusFull <= next_statusCount == STAT_W'(STATUS_DEPTH);
            statusFullPulse <= next_statusCount == STAT_W'(STATUS_DEPTH) && !statusFull; // R4
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit sequencer

    // Suspension acts at frame boundaries only
    always_comb begin
        canStart = txEnable && !stopRequest; // R5 R7
        if (statusFull && !statusOverrunAllow) begin
            canStart = 1'b0; // R3
        end
        if (storeAndForward) begin
            canStart = canStart && frameCount != '0; // R12
        end else begin
            canStart = canStart && (frameCount != '0 || usedCount >= COUNT_W'(startLevel)); // R13
        end
    end

    always_ff @(posedge clk) begin
        if (reset || dataFlush) begin
            state <= tx_ctl_pkg::TX_IDLE;
            linkValid <= 1'b0;
            linkWord <= '0;
        end else begin
            unique case (state)
                tx_ctl_pkg::TX_IDLE: begin
                    if (canStart) begin
                        state <= tx_ctl_pkg::TX_FETCH;
                    end
                end
                tx_ctl_pkg::TX_FETCH: begin
                    // Cut-through stalls here if the host falls behind
                    if (rdIssue) begin
                        state <= tx_ctl_pkg::TX_WAITDATA;
                    end
                end
                tx_ctl_pkg::TX_WAITDATA: begin
                    linkValid <= 1'b1;
                    linkWord <= ramData;
                    state <= tx_ctl_pkg::TX_SEND;
                end
                tx_ctl_pkg::TX_SEND: begin
                    if (linkReady) begin
                        linkValid <= 1'b0;
                        state <= linkWord.last ? tx_ctl_pkg::TX_IDLE : tx_ctl_pkg::TX_FETCH;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    chk_status_flush: assert property (@(posedge clk) disable iff (reset) // R1
        statusFlush |=> statusCount == '0 && !statusFull)
        else $error("status flush left status words");

    chk_data_flush: assert property (@(posedge clk) disable iff (reset) // R2
        dataFlush |=> usedCount == '0 && wrPtr == '0 && rdPtr == '0 && state == tx_ctl_pkg::TX_IDLE)
        else $error("data flush left data pointers");

    chk_full_suspend: assert property (@(posedge clk) disable iff (reset) // R3
        state == tx_ctl_pkg::TX_IDLE && statusFull && !statusOverrunAllow |=> state == tx_ctl_pkg::TX_IDLE)
        else $error("frame started with full status FIFO");

    chk_full_event: assert property (@(posedge clk) disable iff (reset) // R4
        $rose(statusFull) |-> statusFullPulse)
        else $error("status full event missing");

    chk_disabled_idle: assert property (@(posedge clk) disable iff (reset) // R5
        state == tx_ctl_pkg::TX_IDLE && !txEnable |=> state == tx_ctl_pkg::TX_IDLE)
        else $error("frame started while disabled");

    chk_stop_halt: assert property (@(posedge clk) disable iff (reset) // R6
        stopRequest && state == tx_ctl_pkg::TX_IDLE |=> !txEnable && !stopRequest)
        else $error("stop did not clear enable and stop");

    chk_stop_frame: assert property (@(posedge clk) disable iff (reset) // R7
        stopRequest && state == tx_ctl_pkg::TX_SEND |=> stopRequest)
        else $error("stop cleared mid frame");

    chk_stop_ignore: assert property (@(posedge clk) disable iff (reset) // R8
        stopRequest && !haltNow && busWrite && hitTxCfg |=> stopRequest)
        else $error("write changed a pending stop");

    chk_strap_hold: assert property (@(posedge clk) disable iff (reset) // R9
        strapTaken |=> strapLatched == $past(strapLatched))
        else $error("strap copy changed after capture");

    chk_sf_wait: assert property (@(posedge clk) disable iff (reset) // R12
        state == tx_ctl_pkg::TX_IDLE && storeAndForward && frameCount == '0 |=> state == tx_ctl_pkg::TX_IDLE)
        else $error("store and forward started without a whole frame");

    chk_rx_share: assert property (@(posedge clk) disable iff (reset) // R19
        !$past(reset) |-> rxSpaceKb == `TXC_TOTAL_KB - {1'b0, $past(sizeClamped)})
        else $error("receive share wrong");

endmodule

// [tx_mac_model.sv]
// Link-side MAC model that takes words from the transmit block
`timescale 1ns/1ps

module tx_mac_model (
    input wire logic clk, // System clock
    input wire logic reset, // Synchronous reset, active high
    input wire logic slow, // Gaps between accepts when high
    input wire logic linkValid, // Word offered
    input wire tx_ctl_pkg::link_word_type linkWord, // Offered word
    output logic linkReady // Word taken
);
    int words;
    int frames;
    logic [31:0] lastData;
    logic phase;

    // A slow MAC still drains, only with a gap after every ready cycle
    assign linkReady = !reset && (!slow || phase);

    always_ff @(posedge clk) begin
        if (reset) begin
            words <= 0;
            frames <= 0;
            phase <= 1'b0;
            lastData <= 32'h0;
        end else begin
            phase <= !phase;
            if (linkValid && linkReady) begin
                words <= words + 1;
                lastData <= linkWord.data;
                if (linkWord.last) begin
                    frames <= frames + 1;
                end
            end
        end
    end
endmodule

// [tx_control_and_fifo_sizing_tb.sv]
// Testbench of the transmit control block over APB and the fill stream
`timescale 1ns/1ps

module tx_control_and_fifo_sizing_tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic fillValid = 1'b0;
    tx_ctl_pkg::link_word_type fillWord = '0;
    logic fillReady;
    logic linkValid;
    tx_ctl_pkg::link_word_type linkWord;
    logic linkReady;
    logic statusFull;
    logic statusFullPulse;
    logic [4:0] rxSpaceKb;
    logic slow = 1'b0;
    logic [31:0] rd;
    logic err;
    int bad_count = 0;
    int check_count = 0;
    int pulses = 0;
    int n;

    always #20 clk = ~clk;

    always @(posedge clk) begin
        if (statusFullPulse === 1'b1) begin
            pulses = pulses + 1;
        end
    end

    // Small thresholds at index 0 keep the cut-through cases short
    tx_control #(.STATUS_DEPTH(4), .START_FAST(48'h200_100_080_008), .START_SLOW(48'h100_080_040_004)) i_dut (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .autoCrossoverStrap(1'b1),
        .fillValid(fillValid), .fillWord(fillWord), .fillReady(fillReady), .linkValid(linkValid),
        .linkWord(linkWord), .linkReady(linkReady), .statusPop(1'b0), .statusFull(statusFull),
        .statusFullPulse(statusFullPulse), .rxSpaceKb(rxSpaceKb));

    tx_mac_model i_mac (.clk(clk), .reset(reset), .slow(slow), .linkValid(linkValid), .linkWord(linkWord),
        .linkReady(linkReady));

    task summarize;
        if (bad_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("[ERR] %0t mismatch got %h expected %h", $time, got, exp);
        end
    endtask

    task hang;
        bad_count = bad_count + 1;
        $display("[ERR] %0t wait ran out", $time);
        summarize();
    endtask

    // Called just after a rising edge; ends one idle edge later
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        logic hit;
        hit = 1'b0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Answer is taken at the rising edge that sees pready high
        for (int i = 0; i < 50 && !hit; i++) begin
            @(posedge clk);
            hit = (pready === 1'b1);
            rd = prdata;
            err = pslverr;
        end
        if (!hit) hang();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task push(input logic [31:0] d, input logic last);
        logic hit;
        hit = 1'b0;
        fillValid <= 1'b1;
        fillWord <= {last, d};
        for (int i = 0; i < 200 && !hit; i++) begin
            @(posedge clk);
            hit = (fillReady === 1'b1);
        end
        if (!hit) hang();
        fillValid <= 1'b0;
        @(posedge clk);
    endtask

    task waitWords(input int w);
        for (int i = 0; i < 300 && i_mac.words < w; i++) begin
            @(posedge clk);
        end
        if (i_mac.words < w) hang();
    endtask

    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        apb(1'b0, 8'h70, 32'h0); chk(rd, 32'h0);
        apb(1'b0, 8'h74, 32'h0); chk(rd, 32'h0105_0000);
        chk({27'h0, rxSpaceKb}, 32'd11);
        apb(1'b0, 8'h7C, 32'h0); chk({31'h0, err}, 32'h1);
        // Smallest legal allocation, store-and-forward
        apb(1'b1, 8'h74, 32'h0012_0000);
        @(posedge clk);
        chk({27'h0, rxSpaceKb}, 32'd14);
        apb(1'b0, 8'h74, 32'h0); chk(rd, 32'h0112_0000);
        for (n = 0; n < 384; n++) push(n, 1'b0);
        repeat (3) @(posedge clk);
        chk({31'h0, fillReady}, 32'h0);
        apb(1'b0, 8'h78, 32'h0); chk(rd, 32'h0180_0000);
        apb(1'b1, 8'h70, 32'h0000_4000);
        apb(1'b0, 8'h70, 32'h0); chk(rd, 32'h0);
        apb(1'b0, 8'h78, 32'h0); chk(rd, 32'h0);
        apb(1'b1, 8'h70, 32'h0000_0002);
        push(32'hA1, 1'b0);
        push(32'hA2, 1'b0);
        repeat (10) @(posedge clk);
        chk(i_mac.words, 32'd0);
        push(32'hA3, 1'b1);
        waitWords(3);
        chk(i_mac.lastData, 32'hA3);
        // Cut-through: mode 0 needs 8 words, mode 1 only 4
        apb(1'b1, 8'h74, 32'h0002_0000);
        slow <= 1'b1;
        for (n = 0; n < 4; n++) push(n, 1'b0);
        repeat (10) @(posedge clk);
        chk(i_mac.words, 32'd3);
        apb(1'b1, 8'h74, 32'h0022_0000);
        waitWords(7);
        push(32'hB4, 1'b1);
        waitWords(8);
        chk(i_mac.frames, 32'd2);
        apb(1'b1, 8'h70, 32'h0000_8002);
        apb(1'b0, 8'h78, 32'h0); chk(rd, 32'h0);
        apb(1'b0, 8'h70, 32'h0); chk(rd, 32'h2);
        for (n = 0; n < 4; n++) push(n, 1'b1);
        waitWords(12);
        repeat (3) @(posedge clk);
        chk({31'h0, statusFull}, 32'h1);
        chk(pulses, 32'd1);
        push(32'hC5, 1'b1);
        repeat (20) @(posedge clk);
        chk(i_mac.frames, 32'd6);
        apb(1'b1, 8'h70, 32'h0000_0006);
        waitWords(13);
        chk(pulses, 32'd1);
        // Stop requested while a frame is stalled mid-way
        for (n = 0; n < 4; n++) push(n, 1'b0);
        waitWords(17);
        apb(1'b1, 8'h70, 32'h0000_0007);
        apb(1'b1, 8'h70, 32'h0000_0006);
        apb(1'b0, 8'h70, 32'h0); chk(rd, 32'h7);
        push(32'hD5, 1'b1);
        waitWords(18);
        repeat (5) @(posedge clk);
        apb(1'b0, 8'h70, 32'h0); chk(rd, 32'h4);
        chk(i_mac.frames, 32'd8);
        summarize();
    end
endmodule
